// [rtl/serial_port_pkg.sv]
package serial_port_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned OVERSAMPLE      = 16;
  localparam int unsigned BAUD_300        = 300;
  localparam int unsigned BAUD_1200       = 1200;
  localparam int unsigned BAUD_9600       = 9600;
  localparam int unsigned DIV_300         = CLK_HZ / (BAUD_300 * OVERSAMPLE);
  localparam int unsigned DIV_1200        = CLK_HZ / (BAUD_1200 * OVERSAMPLE);
  localparam int unsigned DIV_9600        = CLK_HZ / (BAUD_9600 * OVERSAMPLE);
  localparam int unsigned DIV_W           = 16;
  localparam int unsigned DATA_BITS       = 7;
  localparam int unsigned FRAME_BITS      = 10;
  localparam logic [6:0]  CHAR_CR         = 7'h0D;
  localparam logic [6:0]  CHAR_LF         = 7'h0A;
  localparam logic [3:0]  MID_TICK        = 4'h7;
  localparam logic [3:0]  LAST_TICK       = 4'hF;
  localparam logic        LINE_IDLE       = 1'b1;

  typedef enum logic [1:0] {
    RATE_300,
    RATE_1200,
    RATE_9600,
    RATE_RSVD
  } rate_type;

  typedef struct packed {
    logic [6:0] data;
    logic       parity_err;
    logic       stop_err;
    logic       eom;
  } rx_char_type;
endpackage

// [rtl/baud_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire serial_port_pkg::rate_type   rate_i,
  output logic                             tick_o
);
  import serial_port_pkg::*;

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;

  always_comb begin
    case (rate_i)
      RATE_300:  limit = DIV_W'(DIV_300 - 1);
      RATE_1200: limit = DIV_W'(DIV_1200 - 1);
      RATE_9600: limit = DIV_W'(DIV_9600 - 1);
      default:   limit = DIV_W'(DIV_9600 - 1);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || count >= limit) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (count >= limit);
    end
  end
endmodule
`default_nettype wire

// [rtl/rs232_half_duplex_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
module rs232_half_duplex_serial_port (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire serial_port_pkg::rate_type     rate_i,
  input  wire logic                          rxd_i,
  output logic                               txd_o,
  input  wire logic                          tx_valid_i,
  input  wire logic [6:0]                    tx_data_i,
  output logic                               tx_ready_o,
  output logic                               rx_valid_o,
  output serial_port_pkg::rx_char_type       rx_char_o,
  output logic                               busy_o
);
  import serial_port_pkg::*;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS
  } rx_state_type;

  logic                 tick;
  logic                 rxd_meta;
  logic                 rxd_sync;
  rx_state_type         rx_state;
  logic [3:0]           rx_phase;
  logic [3:0]           rx_count;
  logic [8:0]           rx_shift;
  logic [6:0]           last_char;
  logic                 tx_active;
  logic [3:0]           tx_phase;
  logic [3:0]           tx_count;
  logic [9:0]           tx_shift;

  ////////////////////////////////////////////////////////////////////////////
  // baud tick, rate only is selectable
  baud_tick_gen u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .rate_i (rate_i),
    .tick_o (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // line synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_meta <= LINE_IDLE;
      rxd_sync <= LINE_IDLE;
    end else begin
      rxd_meta <= rxd_i;
      rxd_sync <= rxd_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver; opens no frame while sending, so our own echo never starts one, but a start seen on the tick a char is taken still runs on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= RX_IDLE;
      rx_phase <= 4'h0;
      rx_count <= 4'h0;
      rx_shift <= 9'h000;
    end else if (tick) begin
      case (rx_state)
        RX_IDLE: begin
          rx_phase <= 4'h0;
          if (!rxd_sync && !tx_active) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          rx_phase <= rx_phase + 1'b1;
          if (rx_phase == MID_TICK) begin
            rx_phase <= 4'h0;
            rx_count <= 4'h0;
            // glitch shorter than half a bit is dropped
            rx_state <= rxd_sync ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          rx_phase <= rx_phase + 1'b1;
          if (rx_phase == LAST_TICK) begin
            rx_shift <= {rxd_sync, rx_shift[8:1]};
            rx_count <= rx_count + 1'b1;
            if (rx_count == 4'(FRAME_BITS - 2)) begin
              rx_state <= RX_IDLE;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // stop bit is the live sample; after eight shifts d0 sits in bit 1 and parity in bit 8
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_char_o  <= '0;
      last_char  <= 7'h00;
    end else begin
      rx_valid_o <= 1'b0;
      if (tick && rx_state == RX_BITS && rx_phase == LAST_TICK
          && rx_count == 4'(FRAME_BITS - 2)) begin
        rx_valid_o           <= 1'b1;
        rx_char_o.data       <= rx_shift[7:1];
        rx_char_o.parity_err <= ~^{rx_shift[8:1]};
        rx_char_o.stop_err   <= ~rxd_sync;
        rx_char_o.eom        <= (last_char == CHAR_CR) && (rx_shift[7:1] == CHAR_LF);
        last_char            <= rx_shift[7:1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter; lsb first, start low, stop high
  // a response char is taken the cycle it is offered, so reply latency is the host logic's
  assign tx_ready_o = !tx_active && (rx_state == RX_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_active <= 1'b0;
      tx_phase  <= 4'h0;
      tx_count  <= 4'h0;
      tx_shift  <= 10'h3FF;
    end else if (tx_valid_i && tx_ready_o) begin
      tx_active <= 1'b1;
      tx_phase  <= 4'h0;
      tx_count  <= 4'h0;
      tx_shift  <= {1'b1, ~^tx_data_i, tx_data_i, 1'b0};
    end else if (tx_active && tick) begin
      tx_phase <= tx_phase + 1'b1;
      if (tx_phase == LAST_TICK) begin
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_count <= tx_count + 1'b1;
        if (tx_count == 4'(FRAME_BITS - 1)) begin
          tx_active <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txd_o <= LINE_IDLE;
    end else begin
      txd_o <= tx_active ? tx_shift[0] : LINE_IDLE;
    end
  end

  assign busy_o = tx_active || (rx_state != RX_IDLE);
endmodule
`default_nettype wire

// [testbench/serial_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker
  import serial_port_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire rate_type    rate_i,
  input wire logic        rxd_i,
  input wire logic        txd_o,
  input wire logic        tx_valid_i,
  input wire logic [6:0]  tx_data_i,
  input wire logic        tx_ready_o,
  input wire logic        rx_valid_o,
  input wire rx_char_type rx_char_o,
  input wire logic        busy_o
);
  localparam int TICK = DIV_9600;
  localparam int FRAME = FRAME_BITS * OVERSAMPLE * TICK;
  localparam int LIM = FRAME + FRAME / 2;
  int   since;
  logic last_cr;
  // saturates, so a later receive never passes for the end of a send
  always_ff @(posedge clk_i) begin
    if (rst_i) since <= LIM;
    else if (tx_valid_i && tx_ready_o) since <= 0;
    else if (since < LIM) since <= since + 1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) last_cr <= 1'b0;
    else if (rx_valid_o) last_cr <= rx_char_o.data == CHAR_CR;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s; tx_valid_i && tx_ready_o; endsequence
  sequence start_s; !tx_ready_o ##1 !txd_o; endsequence
  AST_TX_START: assert property (take_s |=> start_s) else $error("no start bit");
  AST_HALF_DUPLEX: assert property (tx_ready_o == !busy_o) else $error("ready busy");
  AST_NO_RX_IN_TX: assert property (since < FRAME |-> !rx_valid_o) else $error("rx in tx");
  AST_FRAME_LEN: assert property ($rose(tx_ready_o) && since < LIM |->
    since >= FRAME - TICK && since <= FRAME + TICK + 4) else $error("frame length");
  AST_STOP_IDLE: assert property ($rose(tx_ready_o) |-> txd_o) else $error("line low");
  AST_RESET_IDLE: assert property (disable iff (1'b0) rst_i |=> txd_o && !rx_valid_o)
    else $error("reset state");
  AST_RX_PULSE: assert property (rx_valid_o |=> !rx_valid_o) else $error("long pulse");
  AST_EOM: assert property (rx_valid_o |->
    rx_char_o.eom == (rx_char_o.data == CHAR_LF && last_cr)) else $error("end mark");
endmodule
bind rs232_half_duplex_serial_port serial_port_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .rate_i(rate_i), .rxd_i(rxd_i), .txd_o(txd_o), .tx_valid_i(tx_valid_i),
  .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
  .rx_char_o(rx_char_o), .busy_o(busy_o));
`default_nettype wire

// [testbench/host_port.sv]
`timescale 1ns/1ps
`default_nettype none
module host_port
  import serial_port_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic txd_i,
  output var logic  rxd_o
);
  localparam int BIT = OVERSAMPLE * DIV_9600;
  initial rxd_o = LINE_IDLE;
  // bad flips parity and pulls the stop bit low
  task automatic send(input logic [6:0] d, input logic bad);
    logic [9:0] f;
    f = {~bad, ~^d ^ bad, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i) rxd_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
    @(posedge clk_i) rxd_o <= LINE_IDLE;
  endtask
  task automatic recv(output logic [9:0] f);
    int n;
    n = 0;
    while (txd_i && n < 4 * BIT) begin
      @(negedge clk_i);
      n++;
    end
    repeat (BIT / 2) @(negedge clk_i);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd_i;
      repeat (BIT) @(negedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// [testbench/rs232_half_duplex_serial_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rs232_half_duplex_serial_port_tb;
  import serial_port_pkg::*;
  localparam int BIT = OVERSAMPLE * DIV_9600;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rxd;
  logic        txd;
  logic        tx_valid = 1'b0;
  logic [6:0]  tx_data = 7'h00;
  logic        tx_ready;
  logic        rx_valid;
  logic        busy;
  rx_char_type rx_char;
  int          err_count = 0;
  int          checked = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  rs232_half_duplex_serial_port dut (.clk_i(clk), .rst_i(rst), .rate_i(RATE_9600),
    .rxd_i(rxd), .txd_o(txd), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_char_o(rx_char), .busy_o(busy));
  host_port host (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  //////////////////////////////////////////////////
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1_500_000) begin
      err_count++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge clk);
    chk({7'h00, txd, tx_ready, rx_valid}, 10'h006);
    chk(rx_char, 10'h000);
  endtask
  // host talks over the send on purpose; the receiver must stay deaf
  task automatic t_tx(input logic [6:0] d);
    logic [9:0] f;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data <= d;
    @(posedge clk);
    tx_valid <= 1'b0;
    fork
      host.recv(f);
      host.send(7'h55, 1'b0);
    join
    chk(f, {1'b1, ~^d, d, 1'b0});
    chk(rx_char, 10'h000);
    chk({9'h000, tx_ready}, 10'h001);
  endtask
  task automatic t_rx(input logic [6:0] d, input logic bad, input logic eom);
    logic [9:0] got;
    int n;
    n = 0;
    got = 10'h000;
    fork
      host.send(d, bad);
      begin
        while (rx_valid !== 1'b1 && n < 12 * BIT) begin
          @(negedge clk);
          n++;
        end
        got = rx_char;
      end
    join
    chk(got, {d, bad, bad, eom});
    // a low stop bit must end before the next start, or it reads as a new edge
    repeat (BIT) @(posedge clk);
  endtask
  //////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_tx(7'h41);
    t_rx(CHAR_LF, 1'b1, 1'b0);
    t_rx(CHAR_CR, 1'b0, 1'b0);
    t_rx(CHAR_LF, 1'b0, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
